//--- include/ide_select_pkg.sv
/*
  Constants for the disk interface select decoder: host I/O address
  windows, strap reset values and reset-window timing.
  Assumes a 10-bit ISA I/O address and a single 50 MHz clock.
*/
package ide_select_pkg;
  localparam int ADDR_W = 10;
  localparam int STRAP_W = 2;
  // Command block windows
  localparam logic [ADDR_W-1:0] PRI_CMD_LO = 10'h1f0;
  localparam logic [ADDR_W-1:0] PRI_CMD_HI = 10'h1f7;
  localparam logic [ADDR_W-1:0] SEC_CMD_LO = 10'h170;
  localparam logic [ADDR_W-1:0] SEC_CMD_HI = 10'h177;
  localparam logic [ADDR_W-1:0] XT_CMD_LO = 10'h320;
  localparam logic [ADDR_W-1:0] XT_CMD_HI = 10'h323;
  // Control block windows
  localparam logic [ADDR_W-1:0] PRI_CTL_LO = 10'h3f6;
  localparam logic [ADDR_W-1:0] PRI_CTL_HI = 10'h3f7;
  localparam logic [ADDR_W-1:0] SEC_CTL_LO = 10'h376;
  localparam logic [ADDR_W-1:0] SEC_CTL_HI = 10'h377;
  // Reset values
  localparam logic [STRAP_W-1:0] STRAP_RESET = 2'h0;
  localparam logic SELECT_IDLE = 1'b1;
  // Cycles after reset release during which straps are still sampled
  localparam int STRAP_HOLD_CYCLES = 4;
  localparam int HOLD_W = 3;
  typedef enum logic [1:0] {MODE_OFF, MODE_AT_PRI, MODE_AT_SEC, MODE_XT} decode_mode_t;
endpackage

//--- src/ide_select_decode.sv
/*
  Disk interface select decoder: decodes host I/O cycles into the drive's
  lane enables and block selects, senses the drive's wide-transfer line and
  latches the serial configuration straps shared with the lane enable pins.
  Assumes host address, cycle qualifier, wide-transfer and strap pins are
  asynchronous; mode controls come from logic on clk.
*/
// Behaviour
// - AT primary, enabled: low lane enable for 1F0-1F7 and 3F6-3F7.
// - AT secondary: low lane enable for 170-177 and 376-377 instead.
// - XT mode: low lane enable for 320-323, PIO or DMA.
// - High lane enable only AT, wide transfer active, command window.
// - Command block select: 1F0-1F7 / 170-177 in AT, 320-323 in XT.
// - Control block select: 3F6-3F7 AT primary and XT, 376-377 secondary.
// - In AT the drive's wide line is low for 16-bit, high for 8-bit.
// - In XT the same input is the active-low disk DMA acknowledge.
// - Adapter mode: straps on lane pins latched around reset for serial address.
`timescale 1ns/1ns
`default_nettype none
module ide_select_decode (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ide_select_pkg::ADDR_W-1:0] host_addr,
  input wire logic host_io_cycle,
  input wire logic ide_enable,
  input wire logic xt_mode,
  input wire logic secondary_addr,
  input wire logic adapter_mode,
  input wire logic wide_transfer_request_n,
  input wire logic serial_cfg_strap_hi,
  input wire logic serial_cfg_strap_lo,
  output logic ide_low_lane_select_n,
  output logic ide_low_lane_select_oe,
  output logic ide_high_lane_select_n,
  output logic ide_high_lane_select_oe,
  output logic disk_cmd_block_select_n,
  output logic disk_ctl_block_select_n,
  output logic wide_transfer_active,
  output logic disk_dma_ack,
  output logic [ide_select_pkg::STRAP_W-1:0] serial_cfg
);
  import ide_select_pkg::*;

  function automatic logic in_range(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Two-flop synchronisers for pin inputs
  logic [ADDR_W-1:0] addr_s1, addr_s2;
  logic cyc_s1, cyc_s2, wide_s1, wide_s2;
  logic [STRAP_W-1:0] strap_s1, strap_s2;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_s1 <= '0;
      addr_s2 <= '0;
      cyc_s1 <= 1'b0;
      cyc_s2 <= 1'b0;
      wide_s1 <= 1'b1;
      wide_s2 <= 1'b1;
      strap_s1 <= STRAP_RESET;
      strap_s2 <= STRAP_RESET;
    end else begin
      addr_s1 <= host_addr;
      addr_s2 <= addr_s1;
      cyc_s1 <= host_io_cycle;
      cyc_s2 <= cyc_s1;
      wide_s1 <= wide_transfer_request_n;
      wide_s2 <= wide_s1;
      strap_s1 <= {serial_cfg_strap_hi, serial_cfg_strap_lo};
      strap_s2 <= strap_s1;
    end
  end

  // Strap window: open in reset, closes after the synchronisers have filled
  logic [HOLD_W-1:0] hold_cnt;
  logic strap_window;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_cnt <= '0;
      strap_window <= 1'b1;
    end else if (strap_window) begin
      if (hold_cnt == HOLD_W'(STRAP_HOLD_CYCLES - 1)) begin
        strap_window <= 1'b0;
      end
      hold_cnt <= hold_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serial_cfg <= STRAP_RESET;
    end else if (strap_window && adapter_mode) begin
      serial_cfg <= strap_s2;
    end
  end

  // Mode selection
  decode_mode_t mode;
  always_comb begin
    if (!ide_enable) begin
      mode = MODE_OFF;
    end else if (xt_mode) begin
      mode = MODE_XT;
    end else if (secondary_addr) begin
      mode = MODE_AT_SEC;
    end else begin
      mode = MODE_AT_PRI;
    end
  end

  logic cmd_hit, ctl_hit, wide_ok;
  always_comb begin
    cmd_hit = 1'b0;
    ctl_hit = 1'b0;
    wide_ok = 1'b0;
    case (mode)
      MODE_AT_PRI: begin
        cmd_hit = in_range(addr_s2, PRI_CMD_LO, PRI_CMD_HI);
        ctl_hit = in_range(addr_s2, PRI_CTL_LO, PRI_CTL_HI);
        wide_ok = !wide_s2;
      end
      MODE_AT_SEC: begin
        cmd_hit = in_range(addr_s2, SEC_CMD_LO, SEC_CMD_HI);
        ctl_hit = in_range(addr_s2, SEC_CTL_LO, SEC_CTL_HI);
        wide_ok = !wide_s2;
      end
      MODE_XT: begin
        cmd_hit = in_range(addr_s2, XT_CMD_LO, XT_CMD_HI);
        ctl_hit = in_range(addr_s2, PRI_CTL_LO, PRI_CTL_HI);
      end
      default: begin
        cmd_hit = 1'b0;
      end
    endcase
  end

  logic next_low, next_high, next_cmd, next_ctl;
  always_comb begin
    next_cmd = !(cyc_s2 && cmd_hit);
    next_ctl = !(cyc_s2 && ctl_hit);
    next_low = !(cyc_s2 && (cmd_hit || (ctl_hit && mode != MODE_XT)));
    next_high = !(cyc_s2 && cmd_hit && wide_ok);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ide_low_lane_select_n <= SELECT_IDLE;
      ide_high_lane_select_n <= SELECT_IDLE;
      disk_cmd_block_select_n <= SELECT_IDLE;
      disk_ctl_block_select_n <= SELECT_IDLE;
    end else if (strap_window) begin
      ide_low_lane_select_n <= SELECT_IDLE;
      ide_high_lane_select_n <= SELECT_IDLE;
      disk_cmd_block_select_n <= SELECT_IDLE;
      disk_ctl_block_select_n <= SELECT_IDLE;
    end else begin
      ide_low_lane_select_n <= next_low;
      ide_high_lane_select_n <= next_high;
      disk_cmd_block_select_n <= next_cmd;
      disk_ctl_block_select_n <= next_ctl;
    end
  end

  // Lane pins are released while straps may be sampled in adapter mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ide_low_lane_select_oe <= 1'b0;
      ide_high_lane_select_oe <= 1'b0;
    end else begin
      ide_low_lane_select_oe <= !(strap_window && adapter_mode);
      ide_high_lane_select_oe <= !(strap_window && adapter_mode);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wide_transfer_active <= 1'b0;
      disk_dma_ack <= 1'b0;
    end else begin
      wide_transfer_active <= ide_enable && !xt_mode && !wide_s2;
      disk_dma_ack <= ide_enable && xt_mode && !wide_s2;
    end
  end

  // Checks
  property p_pri_low;
    @(posedge clk) disable iff (!rstn)
    (!strap_window && mode == MODE_AT_PRI && cyc_s2 && in_range(addr_s2, PRI_CTL_LO, PRI_CTL_HI))
      |=> !ide_low_lane_select_n;
  endproperty
  a_pri_low: assert property (p_pri_low) else $error("low lane not set on primary control");

  property p_sec_low;
    @(posedge clk) disable iff (!rstn)
    (!strap_window && mode == MODE_AT_SEC && cyc_s2 && in_range(addr_s2, SEC_CMD_LO, SEC_CMD_HI))
      |=> (!ide_low_lane_select_n && !disk_cmd_block_select_n);
  endproperty
  a_sec_low: assert property (p_sec_low) else $error("secondary command window missed");

  property p_xt_low;
    @(posedge clk) disable iff (!rstn)
    (!strap_window && mode == MODE_XT && cyc_s2 && in_range(addr_s2, XT_CMD_LO, XT_CMD_HI))
      |=> !ide_low_lane_select_n;
  endproperty
  a_xt_low: assert property (p_xt_low) else $error("xt low lane not set");

  property p_high_never_xt;
    @(posedge clk) disable iff (!rstn)
    $past(mode) == MODE_XT |-> ide_high_lane_select_n;
  endproperty
  a_high_never_xt: assert property (p_high_never_xt) else $error("high lane in xt mode");

  property p_high_needs_wide;
    @(posedge clk) disable iff (!rstn)
    !ide_high_lane_select_n |-> ($past(wide_s2) == 1'b0 && !disk_cmd_block_select_n);
  endproperty
  a_high_needs_wide: assert property (p_high_needs_wide) else $error("high lane without wide");

  property p_ctl_pri;
    @(posedge clk) disable iff (!rstn)
    (!strap_window && mode != MODE_OFF && mode != MODE_AT_SEC && cyc_s2 && addr_s2 == PRI_CTL_HI)
      |=> !disk_ctl_block_select_n;
  endproperty
  a_ctl_pri: assert property (p_ctl_pri) else $error("control select missed");

  property p_wide_sense;
    @(posedge clk) disable iff (!rstn)
    (ide_enable && !xt_mode && !wide_transfer_request_n) ##1 (ide_enable && !xt_mode)[*2]
      |=> wide_transfer_active;
  endproperty
  a_wide_sense: assert property (p_wide_sense) else $error("wide transfer not sensed");

  property p_dma_ack;
    @(posedge clk) disable iff (!rstn)
    disk_dma_ack |-> ($past(xt_mode) && !wide_transfer_active);
  endproperty
  a_dma_ack: assert property (p_dma_ack) else $error("dma ack outside xt");

  property p_strap_hold;
    @(posedge clk) disable iff (!rstn)
    !strap_window |=> $stable(serial_cfg);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed after window");

  property p_idle_off;
    @(posedge clk) disable iff (!rstn)
    (mode == MODE_OFF || !cyc_s2) |=> (ide_low_lane_select_n && ide_high_lane_select_n &&
      disk_cmd_block_select_n && disk_ctl_block_select_n);
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("select active while idle");
endmodule
`default_nettype wire

//--- tb/disk_drive_model.sv
/*
  Drive-side model of the wide-transfer line.
  Assumes the bench sets the requested width and the DMA acknowledge.
*/
`timescale 1ns/1ns
`default_nettype none
module disk_drive_model (
  input wire logic xt_mode,
  input wire logic want_wide,
  input wire logic dma_ack,
  output logic wide_transfer_request_n
);
  // Low for 16-bit in AT, low for DMA ack in XT
  assign wide_transfer_request_n = xt_mode ? !dma_ack : !want_wide;
endmodule
`default_nettype wire

//--- tb/tb.sv
/*
  Self-checking bench for the disk select decoder.
  Assumes the drive model and the design package are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ide_select_pkg::*;
  logic clk, rstn, cyc, en, xt, sec, adp, want_wide, dack, s_hi, s_lo;
  logic [ADDR_W-1:0] addr;
  logic wreq_n, lo_n, lo_oe, hi_n, hi_oe, cmd_n, ctl_n, wact, dma;
  logic [STRAP_W-1:0] cfg;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  ide_select_decode dut (.clk(clk), .rstn(rstn), .host_addr(addr), .host_io_cycle(cyc),
    .ide_enable(en), .xt_mode(xt), .secondary_addr(sec), .adapter_mode(adp),
    .wide_transfer_request_n(wreq_n), .serial_cfg_strap_hi(s_hi), .serial_cfg_strap_lo(s_lo),
    .ide_low_lane_select_n(lo_n), .ide_low_lane_select_oe(lo_oe), .ide_high_lane_select_n(hi_n),
    .ide_high_lane_select_oe(hi_oe), .disk_cmd_block_select_n(cmd_n),
    .disk_ctl_block_select_n(ctl_n), .wide_transfer_active(wact), .disk_dma_ack(dma),
    .serial_cfg(cfg));
  disk_drive_model drive (.xt_mode(xt), .want_wide(want_wide), .dma_ack(dack),
    .wide_transfer_request_n(wreq_n));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic setm(input logic e, input logic x, input logic s, input logic w, input logic d);
    en = e;
    xt = x;
    sec = s;
    want_wide = w;
    dack = d;
    step(4);
  endtask
  // Expected {low, high, cmd, ctl, wide active, dma ack}, then idle after release
  task automatic acc(input logic [ADDR_W-1:0] a, input logic [5:0] exp);
    addr = a;
    cyc = 1;
    step(4);
    chk({lo_n, hi_n, cmd_n, ctl_n, wact, dma}, exp);
    cyc = 0;
    step(4);
    chk({2'b00, lo_n, hi_n, cmd_n, ctl_n}, 6'h0f);
  endtask
  task automatic t_reset();
    rstn = 0;
    step(6);
    rstn = 1;
    step(2);
    chk({lo_n, hi_n, cmd_n, ctl_n, lo_oe, hi_oe}, 6'b111100);
    cyc = 0;
    step(5);
    chk({2'b00, lo_oe, hi_oe, cfg}, 6'b001110);
    $display("reset and strap test done");
  endtask
  task automatic t_at();
    setm(1, 0, 0, 1, 0);
    acc(10'h1f0, 6'b000110);
    acc(10'h3f7, 6'b011010);
    acc(10'h1ef, 6'b111110);
    acc(10'h1f8, 6'b111110);
    setm(1, 0, 0, 0, 0);
    acc(10'h1f7, 6'b010100);
    acc(10'h3f6, 6'b011000);
    setm(1, 0, 1, 1, 0);
    acc(10'h177, 6'b000110);
    acc(10'h376, 6'b011010);
    acc(10'h1f0, 6'b111110);
    acc(10'h3f7, 6'b111110);
    $display("AT mode test done");
  endtask
  task automatic t_xt();
    setm(1, 1, 0, 1, 1);
    acc(10'h320, 6'b010101);
    acc(10'h323, 6'b010101);
    acc(10'h324, 6'b111101);
    acc(10'h3f6, 6'b111001);
    acc(10'h1f0, 6'b111101);
    setm(1, 1, 0, 1, 0);
    acc(10'h321, 6'b010100);
    $display("XT mode test done");
  endtask
  task automatic t_off();
    setm(0, 0, 0, 1, 0);
    acc(10'h1f0, 6'b111100);
    acc(10'h3f6, 6'b111100);
    $display("disabled test done");
  endtask
  // Mid-run reset outside adapter mode: straps ignored, lane pins driven at once
  task automatic t_rerun();
    adp = 0;
    s_hi = 0;
    s_lo = 1;
    en = 1;
    rstn = 0;
    step(1);
    chk({lo_n, hi_n, cmd_n, ctl_n, wact, dma}, 6'b111100);
    chk({2'b00, lo_oe, hi_oe, cfg}, 6'b000000);
    step(5);
    rstn = 1;
    step(2);
    chk({2'b00, lo_oe, hi_oe, cfg}, 6'b001100);
    step(5);
    chk({2'b00, lo_oe, hi_oe, cfg}, 6'b001100);
    acc(10'h1f0, 6'b000110);
    $display("mid-run reset test done");
  endtask
  initial begin
    rstn = 0;
    cyc = 1;
    addr = 10'h1f0;
    en = 1;
    xt = 0;
    sec = 0;
    adp = 1;
    want_wide = 0;
    dack = 0;
    s_hi = 1;
    s_lo = 0;
    t_reset();
    t_at();
    t_xt();
    t_off();
    t_rerun();
    give_verdict();
  end
endmodule
`default_nettype wire
